// *** rps_pkg.sv ***
// Constants, register map and carrier types for the rail sequencer.
// Assumes a single 200 MHz clock; all intervals except the DCM_CYCLES switching count derive from a 1 us tick.
package rps_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_MV       = 25;
  localparam int STEP_US       = 5;
  localparam int PWM_HOLD_US   = 10;
  localparam int DVS_MASK_US   = 100;
  localparam int DEGLITCH_US   = 30;
  localparam int START_MASK_MS = 10;
  localparam int RESUME_US     = 100;
  localparam int DCM_CYCLES    = 16;
  // Least times round up to whole ticks
  localparam int STEP_TICKS     = (STEP_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int PWM_HOLD_TICKS = (PWM_HOLD_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int DVS_MASK_TICKS = (DVS_MASK_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int DEGLITCH_TICKS = (DEGLITCH_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int RESUME_TICKS   = (RESUME_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int START_MASK_DEF = (START_MASK_MS * 1000000 + TICK_NS - 1) / TICK_NS;

  ////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_RAILS = 5;
  localparam int NUM_PG    = 7;
  localparam int MEM_IDX   = 3;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_RAIL0    = 8'h30;
  localparam logic [7:0] OFS_RAIL1    = 8'h31;
  localparam logic [7:0] OFS_RAIL2    = 8'h32;
  localparam logic [7:0] OFS_MEM_RAIL = 8'h36;
  localparam logic [7:0] OFS_RAIL4    = 8'h34;
  localparam logic [39:0] OFS_RAIL_CTRL = {OFS_RAIL4, OFS_MEM_RAIL, OFS_RAIL2, OFS_RAIL1, OFS_RAIL0};
  localparam logic [7:0] OFS_PG_STAT1 = 8'h40;
  localparam logic [7:0] OFS_PG_MASK1 = 8'h42;
  localparam logic [7:0] OFS_FAULT1   = 8'h44;
  localparam logic [7:0] OFS_FAULT2   = 8'h45;
  localparam logic [7:0] OFS_FORCE_SD = 8'h49;
  localparam logic [7:0] OFS_TERM_LDO = 8'hE9;

  // Rail control fields
  localparam int CTL_SRC_BIT = 7;
  localparam int CTL_EN_BIT  = 6;
  localparam int CTL_DVS_BIT = 5;
  // Termination and force-shutdown control fields
  localparam int TERM_OVR_BIT = 7;
  localparam int TERM_EN_BIT  = 6;
  localparam int FSD_BIT      = 0;
  // Shutdown cause bits in fault_source_two
  localparam int F2_VIN_UV  = 0;
  localparam int F2_LDO3_UV = 1;
  localparam int F2_OTP     = 2;
  localparam int F2_SD_PIN  = 3;
  localparam int F2_FORCE   = 4;

  // Reset values
  localparam logic [7:0] RAIL_CTRL_RST = 8'h00;
  localparam logic [7:0] TERM_RST      = 8'h00;
  localparam logic [6:0] PG_MASK_RST   = 7'h00;

  // Memory rail targets in 25 mV codes: 1.2 V, 1.35 V, 1.1 V
  localparam logic [7:0] MEM_CODE_LO  = 8'h30;
  localparam logic [7:0] MEM_CODE_MID = 8'h36;
  localparam logic [7:0] MEM_CODE_HI  = 8'h2C;

  ////////////////////////////////////////////////////////////////////////
  // Register request from the serial front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rps_reg_req_t;

endpackage : rps_pkg

// *** rps_deglitch.sv ***
// Two-edge deglitch filter counted in time-base ticks.
// Assumes din is already synchronised to mclk.
`timescale 1ns/1ps
module rps_deglitch #(
  parameter int TICKS = 30
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic din,
  output logic      dout
);

  localparam int CW = $clog2(TICKS + 1);
  logic [CW-1:0] cnt_q;

  if (TICKS < 1) begin : g_chk
    $error("rps_deglitch: TICKS must be at least 1");
  end

  // Output follows only after din has differed for TICKS ticks
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      dout  <= 1'b0;
    end else if (din == dout) begin
      cnt_q <= '0;        // Any bounce restarts the wait
    end else if (tick) begin
      if (cnt_q == CW'(TICKS - 1)) begin
        cnt_q <= '0;
        dout  <= din;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule : rps_deglitch

// *** rps_sequencer.sv ***
// Rail sequencer: DVS stepping, PWM forcing, powergood filtering,
// masking, fault recording and emergency shutdown for five rails.
// Assumes a byte register port from a serial front end on mclk and
// asynchronous pins and comparator levels from outside.
`timescale 1ns/1ps
module rps_sequencer
  import rps_pkg::*;
#(
  parameter int          START_MASK_TICKS = START_MASK_DEF,
  parameter logic [39:0] RAIL_ACTIVE_CODE = {5{8'h28}},
  parameter logic [4:0]  DCM_DEGLITCH_EN  = 5'b11101
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire rps_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  input  wire logic         standby_request_n,
  input  wire logic         termination_control_pin,
  input  wire logic         system_power_good,
  input  wire logic         shutdown_request_n,
  input  wire logic         vin_uvlo,
  input  wire logic         ldo3_uvlo,
  input  wire logic         over_temp,
  input  wire logic [1:0]   memory_voltage_select,
  input  wire logic [4:0]   rail_enable_pin,
  input  wire logic [6:0]   pg_compare,
  input  wire logic [4:0]   dcm_detect,
  input  wire logic [4:0]   sw_cycle,
  output logic [4:0]        rail_enable,
  output logic              termination_enable,
  output logic [39:0]       rail_ref_code,
  output logic [4:0]        force_pwm,
  output logic [4:0]        pfm_mode,
  output logic [6:0]        rail_powergood_pin,
  output logic              shutdown_active
);

  localparam int SMW = 14;
  localparam int NS  = 31;
  // Active-low pins idle high so reset does not look like a request
  localparam logic [NS-1:0] SYNC_RST = 31'h48000000;

  if (START_MASK_TICKS < 1 || START_MASK_TICKS >= 2**SMW) begin : g_chk
    $error("rps_sequencer: START_MASK_TICKS out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [5:0]    s3_q;
  logic          stby_n_s, term_s, spg_s, sd_n_s, vuv_s, l3uv_s, otp_s;
  logic [1:0]    msel_s;
  logic [4:0]    enp_s, dcm_s, swc_s;
  logic [6:0]    pgc_s;

  // Two flops before any logic reads a pin
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
    end else begin
      s1_q <= {standby_request_n, termination_control_pin, system_power_good,
               shutdown_request_n, vin_uvlo, ldo3_uvlo, over_temp,
               memory_voltage_select, rail_enable_pin, pg_compare,
               dcm_detect, sw_cycle};
      s2_q <= s1_q;
    end
  end

  assign {stby_n_s, term_s, spg_s, sd_n_s, vuv_s, l3uv_s, otp_s,
          msel_s, enp_s, pgc_s, dcm_s, swc_s} = s2_q;

  // Previous samples for edge detection
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s3_q <= 6'h00;
    end else begin
      s3_q <= {spg_s, swc_s};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Time base: one tick per microsecond
  localparam int TW = $clog2(TICK_CYC);
  logic [TW-1:0] tdiv_q;
  logic          tick_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tdiv_q <= '0;
      tick_q <= 1'b0;
    end else if (tdiv_q == TW'(TICK_CYC - 1)) begin
      tdiv_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tdiv_q <= tdiv_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file
  logic [4:0][7:0] ctrl_q;
  logic [7:0]      term_q;
  logic [6:0]      mask_q;
  logic [7:0]      fsd_q;
  logic [6:0]      fault1_q;
  logic [4:0]      fault2_q;
  logic [6:0]      pg_stat;
  logic [6:0]      pg_fault;
  logic [4:0]      cause;
  logic            fsd_hit;
  logic            sd_now;

  // Rail control registers, one per rail
  for (genvar r = 0; r < NUM_RAILS; r++) begin : g_ctl
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        ctrl_q[r] <= RAIL_CTRL_RST;   // Pin is the enable source
      end else if (reg_req.wr && reg_req.addr == OFS_RAIL_CTRL[r*8 +: 8]) begin
        ctrl_q[r] <= reg_req.wdata;
      end
    end
  end

  // Plain control registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      term_q <= TERM_RST;
      mask_q <= PG_MASK_RST;
      fsd_q  <= 8'h00;
    end else if (reg_req.wr) begin
      if (reg_req.addr == OFS_TERM_LDO) term_q <= reg_req.wdata;
      if (reg_req.addr == OFS_PG_MASK1) mask_q <= reg_req.wdata[6:0];
      if (reg_req.addr == OFS_FORCE_SD) fsd_q <= reg_req.wdata;
    end
  end

  assign fsd_hit = reg_req.wr && reg_req.addr == OFS_FORCE_SD && reg_req.wdata[FSD_BIT];

  // Fault sources: write one to clear, a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault1_q <= 7'h00;
      fault2_q <= 5'h00;
    end else begin
      fault1_q <= (fault1_q & ~((reg_req.wr && reg_req.addr == OFS_FAULT1) ?
                   reg_req.wdata[6:0] : 7'h00)) | pg_fault;
      fault2_q <= (fault2_q & ~((reg_req.wr && reg_req.addr == OFS_FAULT2) ?
                   reg_req.wdata[4:0] : 5'h00)) | cause;
    end
  end

  // Read data one cycle after the request; unmapped reads as zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= 8'h00;
      for (int r = 0; r < NUM_RAILS; r++) begin
        if (reg_req.addr == OFS_RAIL_CTRL[r*8 +: 8]) reg_rdata <= ctrl_q[r];
      end
      case (reg_req.addr)
        OFS_TERM_LDO: reg_rdata <= term_q;
        OFS_PG_STAT1: reg_rdata <= {1'b0, pg_stat};
        OFS_PG_MASK1: reg_rdata <= {1'b0, mask_q};
        OFS_FAULT1:   reg_rdata <= {1'b0, fault1_q};
        OFS_FAULT2:   reg_rdata <= {3'b000, fault2_q};
        OFS_FORCE_SD: reg_rdata <= fsd_q;
        default:      ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory rail target from the three-level select
  logic [7:0] mem_code;

  always_comb begin
    case (msel_s)
      2'b00:   mem_code = MEM_CODE_LO;
      2'b01:   mem_code = MEM_CODE_MID;
      2'b10:   mem_code = MEM_CODE_HI;
      default: mem_code = MEM_CODE_LO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Resume mask after system power good rises
  logic [6:0] res_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      res_q <= 7'h00;
    end else if (spg_s && !s3_q[5]) begin
      res_q <= 7'(RESUME_TICKS);
    end else if (tick_q && res_q != 7'h00) begin
      res_q <= res_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-rail sequencing and scaling
  logic [4:0] en_req, dvs_mask, st_mask, dcm_q, fpwm_d;

  for (genvar r = 0; r < NUM_RAILS; r++) begin : g_rail
    logic [7:0]     act, tgt, ref_q;
    logic [4:0]     delta;
    logic           lpm, lpm_q, win_q, en_q;
    logic [2:0]     step_q;
    logic [6:0]     post_q;
    logic [SMW-1:0] sm_q;
    logic [4:0]     dc_q;

    assign en_req[r] = ctrl_q[r][CTL_SRC_BIT] ? ctrl_q[r][CTL_EN_BIT] : enp_s[r];
    // Memory rail scales from the termination pin, others from standby
    assign lpm   = ctrl_q[r][CTL_DVS_BIT] & ((r == MEM_IDX) ? ~term_s : ~stby_n_s);
    assign act   = (r == MEM_IDX) ? mem_code : RAIL_ACTIVE_CODE[r*8 +: 8];
    assign delta = ctrl_q[r][4:0];
    // Code unit is one 25 mV step, so the step count is the code gap
    assign tgt   = (lpm && act > {3'b000, delta}) ? act - {3'b000, delta} :
                   (lpm ? 8'h00 : act);

    // Reference stepper: one code per STEP_TICKS ticks
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        ref_q  <= 8'h00;
        step_q <= 3'h0;
      end else if (!rail_enable[r]) begin
        ref_q  <= tgt;     // Reference preset to the target before enable
        step_q <= 3'h0;
      end else if (ref_q == tgt) begin
        step_q <= 3'h0;
      end else if (tick_q) begin
        if (step_q == 3'(STEP_TICKS - 1)) begin
          step_q <= 3'h0;
          ref_q  <= (tgt > ref_q) ? ref_q + 1'b1 : ref_q - 1'b1;
        end else begin
          step_q <= step_q + 1'b1;
        end
      end
    end

    // Window from the request change until the post-step mask expires
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        lpm_q  <= 1'b0;
        win_q  <= 1'b0;
        post_q <= 7'h00;
      end else begin
        lpm_q <= lpm;
        if (lpm != lpm_q || ref_q != tgt) begin
          post_q <= 7'h00;
          win_q  <= win_q | (lpm != lpm_q);
        end else if (win_q && post_q == 7'(DVS_MASK_TICKS)) begin
          win_q <= 1'b0;
        end else if (win_q && tick_q) begin
          post_q <= post_q + 1'b1;
        end
      end
    end

    assign fpwm_d[r]   = win_q && (ref_q != tgt || post_q < 7'(PWM_HOLD_TICKS));
    assign dvs_mask[r] = win_q;

    // Fault blanking after each enable, pin or register alike
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        en_q <= 1'b0;
        sm_q <= '0;
      end else begin
        en_q <= rail_enable[r];
        if (rail_enable[r] && !en_q) begin
          sm_q <= SMW'(START_MASK_TICKS);
        end else if (tick_q && sm_q != '0) begin
          sm_q <= sm_q - 1'b1;
        end
      end
    end

    assign st_mask[r] = (sm_q != '0);

    // Light-load mode: slow entry, instant exit
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        dc_q     <= 5'h00;
        dcm_q[r] <= 1'b0;
      end else if (!dcm_s[r]) begin
        dc_q     <= 5'h00;
        dcm_q[r] <= 1'b0;                 // Back to CCM at once
      end else if (!DCM_DEGLITCH_EN[r]) begin
        dcm_q[r] <= 1'b1;
      end else if (swc_s[r] && !s3_q[r] && !dcm_q[r]) begin
        if (dc_q == 5'(DCM_CYCLES - 1)) begin
          dcm_q[r] <= 1'b1;
        end else begin
          dc_q <= dc_q + 1'b1;
        end
      end
    end

    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        rail_ref_code[r*8 +: 8] <= 8'h00;
      end else begin
        rail_ref_code[r*8 +: 8] <= ref_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Powergood filtering and fault tree
  logic [6:0] pg_filt;

  for (genvar p = 0; p < NUM_PG; p++) begin : g_pg
    rps_deglitch #(
      .TICKS (DEGLITCH_TICKS)
    ) u_dg (
      .mclk  (mclk),
      .rst_n (rst_n),
      .tick  (tick_q),
      .din   (pgc_s[p]),
      .dout  (pg_filt[p])
    );
    if (p < NUM_RAILS) begin : g_mon
      assign pg_stat[p]  = pg_filt[p] & rail_enable[p];
      assign pg_fault[p] = rail_enable[p] & ~pg_filt[p] & ~mask_q[p] &
                           ~st_mask[p] & ~dvs_mask[p] & (res_q == 7'h00);
    end else begin : g_ext
      assign pg_stat[p]  = pg_filt[p];
      assign pg_fault[p] = 1'b0;       // External standby rails
    end
  end

  // Shutdown causes besides powergood faults
  assign cause[F2_VIN_UV]  = vuv_s;
  assign cause[F2_LDO3_UV] = l3uv_s;
  assign cause[F2_OTP]     = otp_s;
  assign cause[F2_SD_PIN]  = ~sd_n_s;
  assign cause[F2_FORCE]   = fsd_hit;
  assign sd_now = (|pg_fault) | (|cause);

  ////////////////////////////////////////////////////////////////////////
  // Output stage: shutdown latches until reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shutdown_active    <= 1'b0;
      rail_enable        <= 5'h00;
      termination_enable <= 1'b0;
      force_pwm          <= 5'h00;
      pfm_mode           <= 5'h00;
      rail_powergood_pin <= 7'h00;
    end else begin
      shutdown_active <= shutdown_active | sd_now;
      // One cycle from cause to rails off, well inside 1 us
      rail_enable     <= (shutdown_active | sd_now) ? 5'h00 : en_req;
      termination_enable <= ~(shutdown_active | sd_now) &
                            (term_q[TERM_OVR_BIT] ? term_q[TERM_EN_BIT] : term_s);
      force_pwm          <= fpwm_d & rail_enable;
      pfm_mode           <= dcm_q & ~fpwm_d & rail_enable;
      rail_powergood_pin <= pg_stat;
    end
  end

endmodule : rps_sequencer

// *** rps_seq_checker.sv ***
// Port-level timing checks for the rail sequencer.
// Assumes it is bound onto rps_sequencer; one mclk domain, rst_n synchronous.
`timescale 1ns/1ps
module rps_seq_checker
  import rps_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst_n,
  input wire rps_reg_req_t reg_req,
  input wire logic         shutdown_request_n,
  input wire logic [4:0]   dcm_detect,
  input wire logic [4:0]   rail_enable,
  input wire logic         termination_enable,
  input wire logic [39:0]  rail_ref_code,
  input wire logic [4:0]   force_pwm,
  input wire logic [4:0]   pfm_mode,
  input wire logic         shutdown_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Shutdown causes, latch and effect
  a_sd_pin_latency: assert property (!shutdown_request_n |-> ##[1:4] shutdown_active)
    else $error("shutdown pin not honoured in time");
  a_force_sd_write: assert property (reg_req.wr && reg_req.addr == OFS_FORCE_SD && reg_req.wdata[FSD_BIT]
    |-> ##[1:3] shutdown_active)
    else $error("force shutdown write ignored");
  a_sd_stays_latched: assert property (shutdown_active |=> shutdown_active)
    else $error("shutdown released without reset");
  a_sd_rails_off: assert property (shutdown_active |-> rail_enable == 5'h00 && !termination_enable)
    else $error("rail still on during shutdown");

  ////////////////////////////////////////////////////////////////////////
  // Conduction mode; rail 0 stands for the deglitched rails
  a_ccm_exit_fast: assert property ((!dcm_detect[0]) [*5] |-> !pfm_mode[0])
    else $error("light-load mode kept after load rise");
  a_pwm_excludes_pfm: assert property ((force_pwm & pfm_mode) == 5'h00)
    else $error("light-load mode while forced PWM");

  ////////////////////////////////////////////////////////////////////////
  // Reference stepping on an enabled rail
  a_ref_unit_step: assert property (rail_enable[0] && $past(rail_enable[0]) && $changed(rail_ref_code[7:0])
    |-> (rail_ref_code[7:0] - $past(rail_ref_code[7:0]) == 8'h01)
     || ($past(rail_ref_code[7:0]) - rail_ref_code[7:0] == 8'h01))
    else $error("reference moved by more than one step");
  a_ref_step_hold: assert property (rail_enable[0] && $changed(rail_ref_code[7:0])
    |=> (!rail_enable[0] || $stable(rail_ref_code[7:0])) [*8])
    else $error("reference step not held");
endmodule : rps_seq_checker

bind rps_sequencer rps_seq_checker u_chk (
  .mclk               (mclk),
  .rst_n              (rst_n),
  .reg_req            (reg_req),
  .shutdown_request_n (shutdown_request_n),
  .dcm_detect         (dcm_detect),
  .rail_enable        (rail_enable),
  .termination_enable (termination_enable),
  .rail_ref_code      (rail_ref_code),
  .force_pwm          (force_pwm),
  .pfm_mode           (pfm_mode),
  .shutdown_active    (shutdown_active)
);

// *** rps_host_model.sv ***
// Host-side pins: standby, shutdown and system power good.
// Assumes bench requests are levels set on the falling edge; pins follow at the next rising edge.
`timescale 1ns/1ps
module rps_host_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic lpm_req,
  input  wire logic sd_req,
  output logic      standby_request_n  = 1'b1,
  output logic      shutdown_request_n = 1'b1,
  output logic      system_power_good  = 1'b0
);
  // Non-blocking update on the rising edge, so falling-edge bench levels are taken without a race
  always @(posedge mclk) begin
    standby_request_n  <= !lpm_req;
    shutdown_request_n <= !sd_req;
    system_power_good  <= rst_n; // Resume edge after every reset
  end
endmodule : rps_host_model

// *** testbench.sv ***
// Self-checking bench for the rail sequencer.
// Assumes the host model drives standby/shutdown/system power good pins; bench drives the rest.
`timescale 1ns/1ps
`define RPS_CMP(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  import rps_pkg::*;
  typedef struct packed {logic [2:0] sel; logic [7:0] msk; logic [7:0] val;} rps_exp_t;
  logic         mclk = 1'b0;
  logic         rst_n = 1'b0;
  rps_reg_req_t reg_req = '0;
  logic [7:0]   reg_rdata;
  logic         standby_request_n, shutdown_request_n, system_power_good;
  logic         lpm_req = 1'b0, sd_req = 1'b0, term_pin = 1'b0, probe = 1'b0;
  logic         vin_uvlo = 1'b0, ldo3_uvlo = 1'b0, over_temp = 1'b0;
  logic [1:0]   mem_sel = 2'h0;
  logic [4:0]   en_pin = 5'h00, dcm_detect = 5'h00, sw_cycle = 5'h00;
  logic [6:0]   pg_compare = 7'h7F;
  logic [4:0]   rail_enable, force_pwm, pfm_mode;
  logic         termination_enable, shutdown_active;
  logic [39:0]  rail_ref_code;
  logic [6:0]   rail_powergood_pin;
  rps_exp_t     exp_q[$];
  rps_exp_t     e;
  logic [7:0]   o;
  int           miscompares = 0;
  int           comparisons = 0;

  // 200 MHz clock; switching cycles toggle freely
  always #2.5 mclk = ~mclk;
  always @(negedge mclk) sw_cycle <= ~sw_cycle;

  rps_sequencer #(.START_MASK_TICKS(20)) DUT (
    .mclk(mclk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .standby_request_n(standby_request_n), .termination_control_pin(term_pin),
    .system_power_good(system_power_good), .shutdown_request_n(shutdown_request_n),
    .vin_uvlo(vin_uvlo), .ldo3_uvlo(ldo3_uvlo), .over_temp(over_temp),
    .memory_voltage_select(mem_sel), .rail_enable_pin(en_pin), .pg_compare(pg_compare),
    .dcm_detect(dcm_detect), .sw_cycle(sw_cycle), .rail_enable(rail_enable),
    .termination_enable(termination_enable), .rail_ref_code(rail_ref_code),
    .force_pwm(force_pwm), .pfm_mode(pfm_mode), .rail_powergood_pin(rail_powergood_pin),
    .shutdown_active(shutdown_active));

  rps_host_model u_host (
    .mclk(mclk), .rst_n(rst_n), .lpm_req(lpm_req), .sd_req(sd_req),
    .standby_request_n(standby_request_n), .shutdown_request_n(shutdown_request_n),
    .system_power_good(system_power_good));

  ////////////////////////////////////////////////////////////////////////
  // Watcher: pre-update values at the edge are the settled ones
  always @(posedge mclk) begin
    if (probe) begin
      e = exp_q.pop_front();
      case (e.sel)
        3'h0:    o = reg_rdata;
        3'h1:    o = rail_ref_code[31:24];
        3'h2:    o = rail_ref_code[7:0];
        3'h3:    o = {1'b0, shutdown_active, termination_enable, rail_enable};
        3'h5:    o = {3'h0, pfm_mode};
        3'h6:    o = {1'b0, rail_powergood_pin};
        default: o = {3'h0, force_pwm};
      endcase
      `RPS_CMP(o & e.msk, e.val & e.msk)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Drivers; every task starts and ends on a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic ticks(input int n);
    cyc(n * TICK_CYC);
  endtask : ticks
  task automatic chk(input logic [2:0] s, input logic [7:0] v, input logic [7:0] m);
    exp_q.push_back('{sel: s, msk: m, val: v});
    probe = 1'b1;
    cyc(1);
    probe = 1'b0;
    cyc(1);
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
    reg_req = '0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    reg_req = '0;
    chk(3'h0, v, m);
  endtask : rd
  task automatic do_reset;
    rst_n = 1'b0;
    cyc(6);
    rst_n = 1'b1;
    cyc(4);
  endtask : do_reset
  task automatic summarize;
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] ra [5];
    logic [7:0] mc [4];
    logic [7:0] m;
    int         d;
    ra = '{OFS_MEM_RAIL, OFS_FORCE_SD, OFS_TERM_LDO, OFS_PG_MASK1, 8'h00};
    mc = '{MEM_CODE_LO, MEM_CODE_MID, MEM_CODE_HI, MEM_CODE_LO};
    void'($urandom(19964));
    dcm_detect = 5'($urandom) & 5'h1E;
    do_reset();
    // Reset values, plus an unmapped offset reading zero
    for (int i = 0; i < 5; i++) rd(ra[i], 8'h00, 8'hFF);
    m = 8'($urandom);
    wr(OFS_PG_MASK1, m);
    rd(OFS_PG_MASK1, m, 8'h7F);
    wr(OFS_PG_MASK1, 8'h00);
    // Termination regulator: override on, override off, pin path
    wr(OFS_TERM_LDO, 8'hC0);
    cyc(4);
    chk(3'h3, 8'h20, 8'h20);
    wr(OFS_TERM_LDO, 8'h80);
    term_pin = 1'b1;
    cyc(4);
    chk(3'h3, 8'h00, 8'h20);
    wr(OFS_TERM_LDO, 8'h00);
    cyc(4);
    chk(3'h3, 8'h20, 8'h20);
    // Memory rail target from the select pin, rail disabled
    for (int i = 0; i < 4; i++) begin
      mem_sel = 2'(i);
      cyc(4);
      chk(3'h1, mc[i], 8'hFF);
    end
    // Enable source: pin by default, then register
    en_pin = 5'h01;
    cyc(4);
    chk(3'h3, 8'h01, 8'h1F);
    d = 1 + ($urandom % 4);
    wr(OFS_RAIL0, 8'hA0 | 8'(d));
    cyc(4);
    chk(3'h3, 8'h00, 8'h01);
    wr(OFS_RAIL0, 8'hE0 | 8'(d));
    cyc(4);
    chk(3'h3, 8'h01, 8'h01);
    // Downward scaling by d steps, then back up
    lpm_req = 1'b1;
    ticks(1);
    chk(3'h4, 8'h01, 8'h01);
    ticks(5 * d + 2);
    chk(3'h2, 8'h28 - 8'(d), 8'hFF);
    chk(3'h4, 8'h01, 8'h01);
    ticks(12);
    chk(3'h4, 8'h00, 8'h01);
    lpm_req = 1'b0;
    ticks(5 * d + 2);
    chk(3'h2, 8'h28, 8'hFF);
    // Light load on rail 0: 16 switching edges before entry, exit at once
    ticks(20);
    dcm_detect = dcm_detect | 5'h01;
    cyc(12);
    chk(3'h5, 8'h00, 8'h01);
    cyc(40);
    chk(3'h5, 8'h01, 8'h01);
    dcm_detect = dcm_detect & 5'h1E;
    cyc(4);
    chk(3'h5, 8'h00, 8'h01);
    // Faults only after scaling and resume masks expire
    ticks(90);
    pg_compare = 7'h1F;
    ticks(40);
    chk(3'h3, 8'h01, 8'h41);
    rd(OFS_PG_STAT1, 8'h01, 8'h61);
    chk(3'h6, 8'h01, 8'h61);
    pg_compare = 7'h7E;
    ticks(20);
    pg_compare = 7'h7F;
    ticks(40);
    chk(3'h3, 8'h01, 8'h41);
    wr(OFS_PG_MASK1, 8'h01);
    pg_compare = 7'h7E;
    ticks(40);
    chk(3'h3, 8'h01, 8'h41);
    rd(OFS_PG_STAT1, 8'h00, 8'h01);
    wr(OFS_PG_MASK1, 8'h00);
    cyc(6);
    chk(3'h3, 8'h40, 8'h7F);
    rd(OFS_FAULT1, 8'h01, 8'h7F);
    // Every fault_source_two shutdown cause, each from a fresh reset
    for (int i = 0; i < 5; i++) begin
      {vin_uvlo, ldo3_uvlo, over_temp, sd_req} = 4'h0;
      pg_compare = 7'h7F;
      do_reset();
      {vin_uvlo, ldo3_uvlo, over_temp, sd_req} = 4'(8 >> i);
      if (i == 4) wr(OFS_FORCE_SD, 8'h01);
      cyc(8);
      chk(3'h3, 8'h40, 8'h7F);
      rd(OFS_FAULT2, 8'(1 << i), 8'h1F);
    end
    summarize();
  end
endmodule : testbench
